// ---- src/crets_pkg.sv ----
package crets_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 40;
   localparam int POR_MIN_NS = 1000000;
   localparam int POR_MIN_CYC = (POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_MAX_NS = 10000000;
   localparam int RST_MAX_CYC = RST_MAX_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 18;

   // ==========================================================
   // Pin widths and synchroniser layouts
   // ==========================================================
   localparam int REQ_W = 5;
   localparam int RESP_W = 3;
   localparam int CPU_SYNC_W = 9;
   localparam logic [CPU_SYNC_W-1:0] CPU_SYNC_RST = 9'h03f;
   localparam int CS_RST = 8;
   localparam int CS_SUPPLY = 7;
   localparam int CS_ID0 = 6;
   localparam int CS_WARM = 5;
   localparam int CS_THERM = 4;
   localparam int CS_MCE = 3;
   localparam int SYS_SYNC_W = 9;
   localparam logic [SYS_SYNC_W-1:0] SYS_SYNC_RST = 9'h1ff;
   localparam int SS_INTERNAL_ERROR_N = 8;
   localparam int SS_THERM = 7;
   localparam int SS_MCE = 6;
   localparam int SS_STB = 5;

   // ==========================================================
   // Machine-check configuration bits
   // ==========================================================
   localparam int MCE_EN = 0;
   localparam int MCE_INT = 1;
   localparam int MCE_INIT = 2;
   localparam int MCE_OBS = 3;

   // ==========================================================
   // System-end register map
   // ==========================================================
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_RESP = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h00c;
   localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0000;
   localparam int CTRL_SUPPLY = 0;
   localparam int CTRL_RESET = 1;
   localparam int CTRL_THERM = 2;
   localparam int CTRL_WARM = 3;
   localparam int CTRL_ID0 = 4;
   localparam int CTRL_ID1 = 5;
   localparam int CTRL_MCE = 6;
   localparam int CTRL_W = 7;

   typedef enum logic [1:0] {CPU_OFF, CPU_RESET, CPU_RUN} crets_cpu_state_e;
   typedef enum logic [1:0] {SYS_OFF, SYS_POR, SYS_RUN} crets_sys_state_e;

   // Open-drain style two-way lines: a driver pulls only while its enable is low.
   function automatic logic crets_wired(input logic outA, input logic oeNA,
                                        input logic outB, input logic oeNB);
      crets_wired = (oeNA | outA) & (oeNB | outB);
   endfunction

endpackage

// ---- src/crets_if.sv ----
`timescale 1ns/1ps
interface crets_if;
   import crets_pkg::*;

   logic cpuMceOut;
   logic cpuMceOeN;
   logic cpuThermOut;
   logic cpuThermOeN;
   logic cpuIerrN;
   logic [REQ_W-1:0] cpuReqOut;
   logic cpuReqOeN;
   logic cpuStbOut;
   logic cpuStbOeN;

   logic systemResetN;
   logic supplyStable;
   logic platformSupportId0;
   logic platformSupportId1;
   logic warmRestartN;
   logic sysMceOut;
   logic sysMceOeN;
   logic sysThermOut;
   logic sysThermOeN;
   logic [RESP_W-1:0] sysRsOut;
   logic sysRsOeN;
   logic [REQ_W-1:0] sysReqOut;
   logic sysReqOeN;
   logic sysStbOut;
   logic sysStbOeN;

   logic machineCheckErrorN;
   logic thermalAlertN;
   logic internalErrorN;
   logic [REQ_W-1:0] requestCommandN;
   logic addressStrobe0N;
   logic [RESP_W-1:0] responseStatusN;

   // ==========================================================
   // Wire resolution; undriven lines float high through pull-ups.
   // ==========================================================
   assign machineCheckErrorN = crets_wired(cpuMceOut, cpuMceOeN, sysMceOut, sysMceOeN);
   assign thermalAlertN = crets_wired(cpuThermOut, cpuThermOeN, sysThermOut, sysThermOeN);
   assign internalErrorN = cpuIerrN;
   assign requestCommandN = !cpuReqOeN ? cpuReqOut : (!sysReqOeN ? sysReqOut : '1);
   assign addressStrobe0N = !cpuStbOeN ? cpuStbOut : (!sysStbOeN ? sysStbOut : 1'b1);
   assign responseStatusN = !sysRsOeN ? sysRsOut : '1;

   modport cpu (
      output cpuMceOut, cpuMceOeN, cpuThermOut, cpuThermOeN, cpuIerrN,
      output cpuReqOut, cpuReqOeN, cpuStbOut, cpuStbOeN,
      input systemResetN, supplyStable, platformSupportId0, platformSupportId1,
      input warmRestartN, machineCheckErrorN, thermalAlertN, responseStatusN
   );

   modport sys (
      output systemResetN, supplyStable, platformSupportId0, platformSupportId1,
      output warmRestartN, sysMceOut, sysMceOeN, sysThermOut, sysThermOeN,
      output sysRsOut, sysRsOeN, sysReqOut, sysReqOeN, sysStbOut, sysStbOeN,
      input machineCheckErrorN, thermalAlertN, internalErrorN,
      input requestCommandN, addressStrobe0N
   );
endinterface

// ---- src/crets_sync.sv ----
`timescale 1ns/1ps
// A value moves to the output only once the second and third stages agree,
// so a line caught mid-change never reaches the logic.
module crets_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
         stage3 <= RST_VAL;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         dout <= RST_VAL;
      end else if (stage2 == stage3) begin
         dout <= stage3;
      end
   end
endmodule

// ---- src/crets_cpu_end.sv ----
// Overview of operation
// (R1) Any bus agent may pull machine check low.
// (R2) Machine check sources selectable, or fully disabled.
// (R3) Flag set: boot only with id0 low.
// (R4) Flag clear: boot regardless of id0.
// (R5) Id1 input is never used.
// (R6) Thermal alert: output-only or two-way mode.
// (R7) Hot core drives thermal alert active.
// (R8) External alert throttles both cores until released.
// (R9) Supply-stable low until stable, then rises once.
// (R10) Supply-stable may drop; re-raise only when stable.
// (R11) Supply-stable stays high during boundary scan.
// (R12) Only bus owner drives request command type.
// (R13) Request lines travel with the address strobe.
// (R14) Reset entry invalidates caches without write-back.
// (R15) Power-on reset held at least 1 ms.
// (R16) Agents release outputs within two clocks of reset; the CPU end releases them five clocks after the reset pin falls.
// (R17) Reset never held over 10 ms with supply.
// (R18) Reset release latches power-on configuration.
// (R19) Only response agent drives response status.
// (R20) Internal error held until next reset.
// (R21) Warm restart at release starts self-test.
// (R22) External inputs synchronised before use.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module crets_cpu_end
   import crets_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   crets_if.cpu pins,
   input wire logic platformReqFlag,
   input wire logic thermalBidir,
   input wire logic throttleEnable,
   input wire logic [3:0] mceConfig,
   input wire logic [1:0] coreHot,
   input wire logic internalFault,
   input wire logic initiatorError,
   input wire logic observedError,
   input wire logic busOwner,
   input wire logic reqValid,
   input wire logic [REQ_W-1:0] reqType,
   output logic bootAllowed,
   output logic runActive,
   output logic cacheInvalidate,
   output logic bistStart,
   output logic warmLatched,
   output logic id0Latched,
   output logic throttleActive,
   output logic mceSeen,
   output logic [RESP_W-1:0] respStatus
);

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [CPU_SYNC_W-1:0] pinRaw;
   logic [CPU_SYNC_W-1:0] pinSync;
   logic rstSyncN;
   logic supplySync;
   logic id0Sync;
   logic warmSyncN;
   logic thermSyncN;
   logic mceSyncN;
   logic [RESP_W-1:0] rsSyncN;

   // The id1 strap is deliberately left out of this vector. (R5)
   assign pinRaw = {pins.systemResetN, pins.supplyStable, pins.platformSupportId0,
                    pins.warmRestartN, pins.thermalAlertN, pins.machineCheckErrorN,
                    pins.responseStatusN};

   crets_sync #(.W(CPU_SYNC_W), .RST_VAL(CPU_SYNC_RST)) pinSyncInst ( // R22
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .din(pinRaw),
      .dout(pinSync)
   );

   assign rstSyncN = pinSync[CS_RST];
   assign supplySync = pinSync[CS_SUPPLY];
   assign id0Sync = pinSync[CS_ID0];
   assign warmSyncN = pinSync[CS_WARM];
   assign thermSyncN = pinSync[CS_THERM];
   assign mceSyncN = pinSync[CS_MCE];
   assign rsSyncN = pinSync[RESP_W-1:0];

   // ==========================================================
   // Reset sequencing
   // ==========================================================
   crets_cpu_state_e state;
   crets_cpu_state_e next_state;
   logic releaseEdge;
   logic resetEntry;
   logic nextRun;

   // Leaving reset needs supply-stable high; a drop of it forces OFF at once.
   always_comb begin
      next_state = state;
      unique case (state)
         CPU_OFF: begin
            if (supplySync && !rstSyncN) begin
               next_state = CPU_RESET;
            end
         end
         CPU_RESET: begin
            if (!supplySync) begin
               next_state = CPU_OFF;
            end else if (rstSyncN) begin
               next_state = CPU_RUN;
            end
         end
         CPU_RUN: begin
            if (!supplySync) begin
               next_state = CPU_OFF;
            end else if (!rstSyncN) begin
               next_state = CPU_RESET;
            end
         end
         default: begin
            next_state = CPU_OFF;
         end
      endcase
   end

   assign releaseEdge = (state == CPU_RESET) && (next_state == CPU_RUN);
   assign resetEntry = (state != CPU_RESET) && (next_state == CPU_RESET);
   assign nextRun = (next_state == CPU_RUN);

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state <= CPU_OFF;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         runActive <= 1'b0;
         cacheInvalidate <= 1'b0;
      end else begin
         runActive <= nextRun;
         cacheInvalidate <= resetEntry; // R14
      end
   end

   // ==========================================================
   // Power-on configuration and boot gating
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         id0Latched <= 1'b1;
         warmLatched <= 1'b0;
         bistStart <= 1'b0;
      end else begin
         bistStart <= releaseEdge && !warmSyncN; // R21
         if (releaseEdge) begin
            id0Latched <= id0Sync; // R18
            warmLatched <= !warmSyncN; // R18
         end
      end
   end

   // The decision is taken at release and holds for the whole run.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         bootAllowed <= 1'b0;
      end else if (!nextRun) begin
         bootAllowed <= 1'b0;
      end else if (releaseEdge) begin
         bootAllowed <= !platformReqFlag || !id0Sync; // R3 R4
      end
   end

   // ==========================================================
   // Internal error
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pins.cpuIerrN <= 1'b1;
      end else if (state == CPU_RESET || state == CPU_OFF) begin
         pins.cpuIerrN <= 1'b1;
      end else if (nextRun && internalFault) begin
         pins.cpuIerrN <= 1'b0; // R20
      end
   end

   // ==========================================================
   // Machine check
   // ==========================================================
   logic mceCause;

   always_comb begin
      mceCause = (mceConfig[MCE_INT] && internalFault)
               || (mceConfig[MCE_INIT] && initiatorError)
               || (mceConfig[MCE_OBS] && observedError);
   end

   // Every drive below is cleared on the edge after reset is seen. (R16)
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pins.cpuMceOut <= 1'b0;
         pins.cpuMceOeN <= 1'b1;
         mceSeen <= 1'b0;
      end else begin
         pins.cpuMceOut <= 1'b0;
         pins.cpuMceOeN <= !(nextRun && mceConfig[MCE_EN] && mceCause); // R1 R2 R16
         mceSeen <= !mceSyncN;
      end
   end

   // ==========================================================
   // Thermal alert and throttle
   // ==========================================================
   logic coreIsHot;

   assign coreIsHot = |coreHot;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pins.cpuThermOut <= 1'b0;
         pins.cpuThermOeN <= 1'b1;
      end else begin
         pins.cpuThermOut <= 1'b0;
         pins.cpuThermOeN <= !(nextRun && coreIsHot); // R7 R16
      end
   end

   // The wire also reflects our own drive a few cycles late, so the throttle
   // may linger briefly after cooling; that errs on the safe side.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         throttleActive <= 1'b0;
      end else begin
         throttleActive <= nextRun && throttleEnable
                           && (coreIsHot || (thermalBidir && !thermSyncN)); // R6 R8
      end
   end

   // ==========================================================
   // Request command launch and response status
   // ==========================================================
   logic reqLaunch;

   assign reqLaunch = nextRun && busOwner && reqValid; // R12

   // Command and strobe leave from the same edge so they stay aligned. (R13)
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pins.cpuReqOut <= '1;
         pins.cpuReqOeN <= 1'b1;
         pins.cpuStbOut <= 1'b1;
         pins.cpuStbOeN <= 1'b1;
      end else if (reqLaunch) begin
         pins.cpuReqOut <= ~reqType; // R12 R13
         pins.cpuReqOeN <= 1'b0;
         pins.cpuStbOut <= 1'b0;
         pins.cpuStbOeN <= 1'b0;
      end else begin
         pins.cpuReqOut <= '1;
         pins.cpuReqOeN <= 1'b1;
         pins.cpuStbOut <= 1'b1;
         pins.cpuStbOeN <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         respStatus <= '0;
      end else begin
         respStatus <= ~rsSyncN;
      end
   end

endmodule

// ---- src/crets_sys_end.sv ----
`timescale 1ns/1ps
module crets_sys_end
   import crets_pkg::*;
#(
   parameter int PorCycles = POR_MIN_CYC,
   parameter int MaxCycles = RST_MAX_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   crets_if.sys pins
);

   // The hold never exceeds the ceiling, even if the minimum is overridden.
   localparam int HOLD_CYC = (PorCycles < MaxCycles) ? PorCycles : MaxCycles;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [SYS_SYNC_W-1:0] pinSync;

   crets_sync #(.W(SYS_SYNC_W), .RST_VAL(SYS_SYNC_RST)) pinSyncInst ( // R22
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .din({pins.internalErrorN, pins.thermalAlertN, pins.machineCheckErrorN,
            pins.addressStrobe0N, pins.requestCommandN}),
      .dout(pinSync)
   );

   // ==========================================================
   // APB slave
   // ==========================================================
   logic [CTRL_W-1:0] ctrl;
   logic [REQ_W-1:0] cmdCode;
   logic cmdValid;
   logic access;
   logic resetCmd;
   logic respCmd;
   logic runNext;
   crets_sys_state_e state;
   crets_sys_state_e next_state;
   logic [TIMER_W-1:0] timer;

   function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
      addrMapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_RESP)
                || (a == ADDR_CMD);
   endfunction

   assign access = psel && penable && pready;
   assign resetCmd = access && pwrite && (paddr == ADDR_CTRL) && pwdata[CTRL_RESET];
   assign respCmd = access && pwrite && (paddr == ADDR_RESP) && addrMapped(paddr);

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addrMapped(paddr);
         prdata <= '0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               ADDR_CTRL: prdata <= {{(32-CTRL_W){1'b0}}, ctrl};
               ADDR_STATUS: prdata <= {27'h0, state == SYS_RUN, !pins.systemResetN,
                                       !pinSync[SS_INTERNAL_ERROR_N], !pinSync[SS_THERM],
                                       !pinSync[SS_MCE]};
               ADDR_CMD: prdata <= {23'h0, cmdValid, 3'h0, cmdCode};
               default: prdata <= '0;
            endcase
         end
      end
   end

   // The reset bit is a command and never stored.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ctrl <= CTRL_RST_VAL[CTRL_W-1:0];
      end else if (access && pwrite && paddr == ADDR_CTRL) begin
         ctrl <= pwdata[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_RESET);
      end
   end

   // A strobe in the same cycle as the clearing read wins.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cmdCode <= '0;
         cmdValid <= 1'b0;
      end else if (!pinSync[SS_STB]) begin
         cmdCode <= ~pinSync[REQ_W-1:0]; // R13
         cmdValid <= 1'b1;
      end else if (access && !pwrite && paddr == ADDR_CMD) begin
         cmdValid <= 1'b0;
      end
   end

   // ==========================================================
   // Supply and reset sequencing
   // ==========================================================
   always_comb begin
      next_state = state;
      unique case (state)
         SYS_OFF: begin
            if (ctrl[CTRL_SUPPLY]) begin
               next_state = SYS_POR;
            end
         end
         SYS_POR: begin
            if (!ctrl[CTRL_SUPPLY]) begin
               next_state = SYS_OFF;
            end else if (timer == TIMER_W'(HOLD_CYC - 1)) begin
               next_state = SYS_RUN; // R15 R17
            end
         end
         SYS_RUN: begin
            if (!ctrl[CTRL_SUPPLY]) begin
               next_state = SYS_OFF;
            end else if (resetCmd) begin
               next_state = SYS_POR;
            end
         end
         default: begin
            next_state = SYS_OFF;
         end
      endcase
   end

   assign runNext = (next_state == SYS_RUN);

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state <= SYS_OFF;
         timer <= '0;
      end else begin
         state <= next_state;
         timer <= (next_state == SYS_POR && state == SYS_POR) ? timer + 1'b1 : '0;
      end
   end

   // Supply-stable comes straight from a flop, so it cannot glitch; every
   // rise passes a fresh full reset hold. (R9 R10 R11)
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         pins.supplyStable <= 1'b0;
         pins.systemResetN <= 1'b0;
         pins.warmRestartN <= 1'b1;
         pins.platformSupportId0 <= 1'b1;
         pins.platformSupportId1 <= 1'b1;
      end else begin
         pins.supplyStable <= ctrl[CTRL_SUPPLY]; // R9 R10
         pins.systemResetN <= runNext; // R15
         pins.warmRestartN <= !ctrl[CTRL_WARM];
         pins.platformSupportId0 <= !ctrl[CTRL_ID0];
         pins.platformSupportId1 <= !ctrl[CTRL_ID1];
      end
   end

   // ==========================================================
   // Sideband drives, all released while reset is applied
   // ==========================================================
   // Status stands two cycles, else the far end's agreeing filter drops it. (R19)
   logic respPend;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         respPend <= 1'b0;
         pins.sysMceOut <= 1'b0;
         pins.sysMceOeN <= 1'b1;
         pins.sysThermOut <= 1'b0;
         pins.sysThermOeN <= 1'b1;
         pins.sysRsOut <= '1;
         pins.sysRsOeN <= 1'b1;
         pins.sysReqOut <= '1;
         pins.sysReqOeN <= 1'b1;
         pins.sysStbOut <= 1'b1;
         pins.sysStbOeN <= 1'b1;
      end else begin
         respPend <= respCmd;
         pins.sysMceOut <= 1'b0;
         pins.sysMceOeN <= !(runNext && ctrl[CTRL_MCE]); // R1 R16
         pins.sysThermOut <= 1'b0;
         pins.sysThermOeN <= !(runNext && ctrl[CTRL_THERM]); // R8 R16
         pins.sysRsOut <= respCmd ? ~pwdata[RESP_W-1:0] : (respPend ? pins.sysRsOut : '1); // R19
         pins.sysRsOeN <= !(runNext && (respCmd || respPend)); // R19 R16
         // This end never owns the request bus, so it leaves those lines alone.
         pins.sysReqOut <= '1; // R12
         pins.sysReqOeN <= 1'b1;
         pins.sysStbOut <= 1'b1;
         pins.sysStbOeN <= 1'b1;
      end
   end

endmodule

// ---- test/crets_props.sv ----
`timescale 1ns/1ps
module crets_props #(
   parameter int PorCycles = 20,
   parameter int MaxCycles = 40
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic supplyStable,
   input wire logic systemResetN,
   input wire logic cpuIerrN,
   input wire logic cpuMceOeN,
   input wire logic cpuThermOeN,
   input wire logic cpuReqOeN,
   input wire logic cpuStbOut,
   input wire logic cpuStbOeN,
   input wire logic sysReqOeN,
   input wire logic sysRsOeN
);
   // Cycles spent in reset with the supply up; both reset limits are judged on it.
   int lowCnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge sys_clk) begin
      if (!rst_b || systemResetN || !supplyStable) begin
         lowCnt <= 0;
      end else begin
         lowCnt <= lowCnt + 1;
      end
   end
   a_por_length: assert property ($rose(systemResetN) |-> lowCnt >= PorCycles)
      else $error("reset released early");
   a_reset_max: assert property (lowCnt <= MaxCycles)
      else $error("reset held too long");
   a_supply_drop: assert property (!supplyStable |=> !systemResetN)
      else $error("reset not taken on supply loss");
   a_strobe_pairs: assert property (!cpuReqOeN |-> !cpuStbOeN && !cpuStbOut)
      else $error("request without strobe");
   a_owner_only: assert property (!cpuReqOeN |-> sysReqOeN)
      else $error("two request drivers");
   a_resp_pulse: assert property ($fell(sysRsOeN) |=> !sysRsOeN ##1 sysRsOeN)
      else $error("response drive too long");
   a_reset_release: assert property ((!systemResetN)[*6] |->
      cpuMceOeN && cpuThermOeN && cpuReqOeN && cpuStbOeN)
      else $error("outputs held in reset");
   a_internal_error_n_hold: assert property (!cpuIerrN && systemResetN |=> !cpuIerrN)
      else $error("internal error dropped");
   cover property ($rose(systemResetN));
   cover property (!cpuReqOeN);
   cover property ($fell(cpuIerrN));
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb
   import crets_pkg::*;
;
   logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic platformReqFlag = 0, thermalBidir = 0, throttleEnable = 0, internalFault = 0;
   logic initiatorError = 0, observedError = 0, busOwner = 0, reqValid = 0;
   logic [3:0] mceConfig = '0;
   logic [1:0] coreHot = '0;
   logic [REQ_W-1:0] reqType = '0;
   logic bootAllowed, warmLatched, id0Latched, throttleActive, mceSeen, hit;
   logic [RESP_W-1:0] respStatus;
   int badCount = 0, nCompared = 0;
   crets_if ifc();
   crets_cpu_end i_crets_cpu_end(.sys_clk(sys_clk), .rst_b(rst_b), .pins(ifc.cpu),
      .platformReqFlag(platformReqFlag), .thermalBidir(thermalBidir),
      .throttleEnable(throttleEnable), .mceConfig(mceConfig), .coreHot(coreHot),
      .internalFault(internalFault), .initiatorError(initiatorError),
      .observedError(observedError), .busOwner(busOwner), .reqValid(reqValid),
      .reqType(reqType), .bootAllowed(bootAllowed), .runActive(), .cacheInvalidate(),
      .bistStart(), .warmLatched(warmLatched), .id0Latched(id0Latched),
      .throttleActive(throttleActive), .mceSeen(mceSeen), .respStatus(respStatus));
   crets_sys_end #(.PorCycles(20), .MaxCycles(40)) i_crets_sys_end(.sys_clk(sys_clk),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(ifc.sys));
   crets_props #(.PorCycles(20), .MaxCycles(40)) i_crets_props(.sys_clk(sys_clk),
      .rst_b(rst_b), .supplyStable(ifc.supplyStable), .systemResetN(ifc.systemResetN),
      .cpuIerrN(ifc.cpuIerrN), .cpuMceOeN(ifc.cpuMceOeN), .cpuThermOeN(ifc.cpuThermOeN),
      .cpuReqOeN(ifc.cpuReqOeN), .cpuStbOut(ifc.cpuStbOut), .cpuStbOeN(ifc.cpuStbOeN),
      .sysReqOeN(ifc.sysReqOeN), .sysRsOeN(ifc.sysRsOeN));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   task finish_test;
      if (badCount == 0 && nCompared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task hang;
      badCount++;
      finish_test();
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task chks(input logic [31:0] e);
      apb(1'b0, ADDR_STATUS, 0);
      chk(rd, e);
   endtask
   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge sys_clk);
      if (i == 20) hang();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wsig(input logic v);
      int i;
      for (i = 0; i < 200 && ifc.systemResetN !== v; i++) @(posedge sys_clk);
      if (i == 200) hang();
   endtask
   task boot(input logic [31:0] c);
      apb(1'b1, ADDR_CTRL, c);
      wsig(1'b0);
      wsig(1'b1);
      wt(8);
   endtask
   task boot_check;
      boot(32'h1);
      chk(bootAllowed, 1);
      platformReqFlag <= 1'b1;
      boot(32'h23);
      chk(bootAllowed, 0);
      boot(32'h1b);
      chk({bootAllowed, warmLatched, id0Latched}, 3'h6);
      apb(1'b0, ADDR_CTRL, 0);
      chk(rd, 32'h19);
   endtask
   task thermal_check;
      throttleEnable <= 1'b1;
      coreHot <= 2'h2;
      wt(8);
      chks(32'h12);
      coreHot <= 2'h0;
      apb(1'b1, ADDR_CTRL, 32'h1d);
      wt(12);
      chk(throttleActive, 0);
      thermalBidir <= 1'b1;
      wt(8);
      chk(throttleActive, 1);
      apb(1'b1, ADDR_CTRL, 32'h19);
      wt(12);
      chk(throttleActive, 0);
   endtask
   task error_check;
      internalFault <= 1'b1;
      wt(8);
      chks(32'h14);
      mceConfig <= 4'h3;
      wt(8);
      chks(32'h15);
      internalFault <= 1'b0;
      mceConfig <= 4'h0;
      wt(8);
      chks(32'h14);
      apb(1'b1, ADDR_CTRL, 32'h59);
      wt(8);
      chk(mceSeen, 1);
      boot(32'h1b);
      chks(32'h10);
   endtask
   task request_check;
      int i;
      busOwner <= 1'b1;
      reqType <= 5'h0b;
      reqValid <= 1'b1;
      wt(2);
      reqValid <= 1'b0;
      wt(8);
      apb(1'b0, ADDR_CMD, 0);
      chk(rd, 32'h10b);
      busOwner <= 1'b0;
      reqType <= 5'h04;
      reqValid <= 1'b1;
      @(posedge sys_clk);
      reqValid <= 1'b0;
      wt(8);
      apb(1'b0, ADDR_CMD, 0);
      chk(rd, 32'h00b);
      apb(1'b1, ADDR_RESP, 32'h5);
      hit = 1'b0;
      for (i = 0; i < 12; i++) begin
         @(posedge sys_clk);
         hit = hit | (respStatus === 3'h5);
      end
      chk(hit, 1);
      apb(1'b0, 12'h010, 0);
      chk(er, 1);
   endtask
   initial begin
      wt(20);
      rst_b <= 1'b1;
      boot_check();
      thermal_check();
      error_check();
      request_check();
      finish_test();
   end
   initial begin
      wt(20000);
      hang();
   end
endmodule
